// ==== src/ddrc_consts.svh ====
// Field positions, codes, reset values and cycle counts of the command decoder
`ifndef DDRC_CONSTS_SVH
`define DDRC_CONSTS_SVH
`define DDRC_BL_LSB 0
`define DDRC_BL_MSB 2
`define DDRC_BT_BIT 3
`define DDRC_CL_LSB 4
`define DDRC_CL_MSB 6
`define DDRC_EMRS_BIT 0
`define DDRC_AP_BIT 10
`define DDRC_BL4 3'h2
`define DDRC_BL8 3'h3
`define DDRC_CL3 3'h3
`define DDRC_CL25 3'h6
`define DDRC_TMRD 2'h2
`define DDRC_MODE_RST 16'h0000
`endif

// ==== src/ddrc_pkg.sv ====
// Types shared by the command decoder files
package ddrc_pkg;
  // Device operating state, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ACTV = 5'h02,
    ST_SREF = 5'h04,
    ST_PPD  = 5'h08,
    ST_APD  = 5'h10
  } ddrc_state_e;
  // Accepted command codes
  typedef enum logic [3:0] {
    CMD_NONE     = 4'h0,
    CMD_NOP      = 4'h1,
    CMD_ACT      = 4'h2,
    CMD_PRE      = 4'h3,
    CMD_PREA     = 4'h4,
    CMD_RD       = 4'h5,
    CMD_WR       = 4'h6,
    CMD_MRS      = 4'h7,
    CMD_EMRS     = 4'h8,
    CMD_BST      = 4'h9,
    CMD_REF      = 4'ha,
    CMD_SREF_IN  = 4'hb,
    CMD_SREF_OUT = 4'hc,
    CMD_PPD_IN   = 4'hd,
    CMD_APD_IN   = 4'he,
    CMD_PD_OUT   = 4'hf
  } ddrc_cmd_e;
endpackage

// ==== src/ddrc_sync.sv ====
// Three-stage level synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module ddrc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q_r
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // Chain; a bit changes once stages two and three agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q_r  <= '0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r  <= (s2_r & s3_r) | (q_r & (s2_r ^ s3_r));
    end
  end
endmodule
`default_nettype wire

// ==== src/ddrc_burst_col.sv ====
// Burst column generator for sequential and interleaved order
`timescale 1ns/1ps
`default_nettype none
module ddrc_burst_col (
  input  wire logic [9:0] start_col,
  input  wire logic [2:0] beat,
  input  wire logic [2:0] len_mask,
  input  wire logic       interleave,
  output logic      [9:0] col
);
  logic [2:0] low;

  // Wrap inside the aligned block, upper bits fixed
  always_comb begin
    low = interleave ? (start_col[2:0] ^ beat) : 3'(start_col[2:0] + beat);
    col = {start_col[9:3], (start_col[2:0] & ~len_mask) | (low & len_mask)};
  end
endmodule
`default_nettype wire

// ==== src/ddrc_cmd_decode.sv ====
// DDR SDRAM command decoder, mode register and burst sequencer
`timescale 1ns/1ps
`default_nettype none
`include "ddrc_consts.svh"
// Contract
// R1 - Low select with row/column/write strobes decodes activate, precharge, read, write
// R2 - Refresh strobes: auto refresh with clock enable high, self refresh when falling
// R3 - Commands need clock enable high one cycle earlier
// R4 - Activate, read, write, precharge act on the addressed bank only; precharge with address bit 10 high closes all four banks
// R5 - All strobes low in idle is a mode register set
// R6 - Burst stop accepted only during a running burst
// R7 - Idle with clock enable falling and no command enters precharge power-down
// R8 - Active with clock enable falling enters active power-down
// R9 - Write byte lanes disabled while their mask input is high
// R10 - Mode register keeps programmed value until rewritten
// R11 - Controller sets mode only with banks idle, no burst, enable high
// R12 - Mode register loads address and bank bits on the command edge
// R13 - Controller waits two cycles after a mode set
// R14 - Burst length bits 0-2, type bit 3, latency bits 4-6
// R15 - Controller writes zero into undefined mode bits
// R16 - Controller never programs reserved codes
// R17 - Length codes 1,2,3 give bursts 2,4,8
// R18 - Bit 3 selects sequential or interleaved order
// R19 - Sequential order increments and wraps inside the aligned block
// R20 - Interleaved order xors start bits with beat counter
// R21 - First read data CAS latency cycles after the read
// R22 - Controller picks the smallest latency meeting access time
// R23 - Controller keeps test bits seven and eight at zero
// R24 - Bank bit zero selects main or extended mode register
// R25 - Latency codes 2,3,6 give 2, 3 and 2.5 clocks
module ddrc_cmd_decode (
  input  wire logic                   clk,
  input  wire logic                   arst_n,
  input  wire logic                   link_ck,
  input  wire logic                   cke,
  input  wire logic                   cs_n,
  input  wire logic                   ras_n,
  input  wire logic                   cas_n,
  input  wire logic                   we_n,
  input  wire logic [1:0]             ba,
  input  wire logic [13:0]            addr,
  input  wire logic                   lower_byte_write_mask,
  input  wire logic                   upper_byte_write_mask,
  output var  ddrc_pkg::ddrc_cmd_e    cmd_r,
  output logic                        cmd_err_r,
  output logic [1:0]                  cmd_bank_r,
  output logic                        cmd_auto_pre_r,
  output var  ddrc_pkg::ddrc_state_e  dev_st_r,
  output logic [3:0]                  bank_open_r,
  output logic                        burst_act_r,
  output logic                        burst_wr_r,
  output logic [9:0]                  col_even_r,
  output logic [9:0]                  col_odd_r,
  output logic [1:0]                  wr_lane_en_r,
  output logic                        rd_start_r,
  output logic                        rd_half_r,
  output logic [15:0]                 mode_r,
  output logic [15:0]                 ext_mode_r,
  output logic                        mode_set_r,
  output logic [15:0]                 sys_mode_r,
  output logic [15:0]                 sys_ext_mode_r,
  output logic [3:0]                  sys_bank_open_r,
  output logic                        sys_self_ref_r
);
  logic [1:0]            rst_sync_r;
  logic [1:0]            lrst_sync_r;
  logic                  rst_n;
  logic                  lrst_n;
  logic                  cke_prev_r;
  logic [2:0]            strb;
  logic                  idle_cmd;
  logic                  pwr;
  logic                  all_idle;
  logic [1:0]            mrd_cnt_r;
  ddrc_pkg::ddrc_cmd_e   cmd_nxt;
  ddrc_pkg::ddrc_state_e st_nxt;
  logic                  err_nxt;
  logic [3:0]            bank_nxt;
  logic                  go;
  logic                  rd_go;
  logic                  wr_go;
  logic                  burst_on;
  logic [1:0]            pairs_left_r;
  logic [1:0]            pair_r;
  logic [1:0]            pairs_m1;
  logic [1:0]            pair_sel;
  logic [9:0]            start_r;
  logic [9:0]            gen_start;
  logic [1:0]            burst_bank_r;
  logic                  burst_ap_r;
  logic [2:0]            len_mask;
  logic                  cl3;
  logic                  cl_half;
  logic [1:0]            rd_pipe_r;
  logic [9:0]            gen_even;
  logic [9:0]            gen_odd;
  logic                  upd_pend_r;
  logic                  req_r;
  logic                  ack_q;
  logic                  req_q;
  logic                  ack_r;
  logic [31:0]           xfer_r;
  logic [4:0]            st_q;

  // Reset release, one copy per clock
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  always_ff @(posedge link_ck or negedge arst_n) begin
    if (!arst_n) begin
      lrst_sync_r <= 2'h0;
    end else begin
      lrst_sync_r <= {lrst_sync_r[0], 1'b1};
    end
  end
  assign rst_n  = rst_sync_r[1];
  assign lrst_n = lrst_sync_r[1];

  // Command qualifiers
  assign strb     = {ras_n, cas_n, we_n};
  assign idle_cmd = cs_n || strb == 3'h7;
  assign pwr      = dev_st_r[2] || dev_st_r[3] || dev_st_r[4];
  assign all_idle = bank_open_r == 4'h0 && !burst_act_r;
  assign go       = rd_go || wr_go;
  assign burst_on = burst_act_r && pairs_left_r != 2'h0 && !go
                    && cmd_nxt != ddrc_pkg::CMD_BST;

  // Mode field decode
  always_comb begin
    case (mode_r[`DDRC_BL_MSB:`DDRC_BL_LSB])
      `DDRC_BL4: begin
        len_mask = 3'h3; // see R17
        pairs_m1 = 2'h1;
      end
      `DDRC_BL8: begin
        len_mask = 3'h7;
        pairs_m1 = 2'h3;
      end
      default: begin
        len_mask = 3'h1;
        pairs_m1 = 2'h0;
      end
    endcase
    cl3     = mode_r[`DDRC_CL_MSB:`DDRC_CL_LSB] == `DDRC_CL3; // see R25
    cl_half = mode_r[`DDRC_CL_MSB:`DDRC_CL_LSB] == `DDRC_CL25;
  end

  // Command decode against device and bank state
  always_comb begin
    cmd_nxt  = ddrc_pkg::CMD_NONE;
    err_nxt  = 1'b0;
    st_nxt   = dev_st_r;
    bank_nxt = bank_open_r;
    rd_go    = 1'b0;
    wr_go    = 1'b0;
    if (burst_act_r && pairs_left_r == 2'h0 && burst_ap_r) begin
      bank_nxt[burst_bank_r] = 1'b0;
    end
    if (pwr) begin
      if (cke && idle_cmd) begin // see R2, R7, R8
        cmd_nxt = dev_st_r[2] ? ddrc_pkg::CMD_SREF_OUT : ddrc_pkg::CMD_PD_OUT;
        st_nxt  = dev_st_r[4] ? ddrc_pkg::ST_ACTV : ddrc_pkg::ST_IDLE;
      end
    end else if (!cke_prev_r) begin
      err_nxt = !cs_n; // see R3
    end else if (!cke) begin
      if (dev_st_r[0] && !cs_n && strb == 3'h1) begin
        cmd_nxt = ddrc_pkg::CMD_SREF_IN; // see R2
        st_nxt  = ddrc_pkg::ST_SREF;
      end else if (dev_st_r[0] && idle_cmd) begin
        cmd_nxt = ddrc_pkg::CMD_PPD_IN; // see R7
        st_nxt  = ddrc_pkg::ST_PPD;
      end else if (dev_st_r[1]) begin
        cmd_nxt = ddrc_pkg::CMD_APD_IN; // see R8
        st_nxt  = ddrc_pkg::ST_APD;
      end else begin
        err_nxt = 1'b1;
      end
    end else if (!cs_n && strb != 3'h7 && mrd_cnt_r != 2'h0) begin
      err_nxt = 1'b1;
    end else if (!cs_n) begin
      case (strb)
        3'h3: begin
          err_nxt = bank_open_r[ba]; // see R1, R4
          if (!bank_open_r[ba]) begin
            cmd_nxt      = ddrc_pkg::CMD_ACT;
            bank_nxt[ba] = 1'b1;
          end
        end
        3'h2: begin
          if (addr[`DDRC_AP_BIT]) begin
            cmd_nxt  = ddrc_pkg::CMD_PREA; // see R1
            bank_nxt = 4'h0;
          end else begin
            cmd_nxt      = ddrc_pkg::CMD_PRE; // see R4
            bank_nxt[ba] = 1'b0;
          end
        end
        3'h5, 3'h4: begin
          err_nxt = !bank_open_r[ba]; // see R4
          rd_go   = bank_open_r[ba] && strb[0];
          wr_go   = bank_open_r[ba] && !strb[0];
          if (rd_go) begin
            cmd_nxt = ddrc_pkg::CMD_RD;
          end else if (wr_go) begin
            cmd_nxt = ddrc_pkg::CMD_WR;
          end
        end
        3'h0: begin
          err_nxt = !all_idle; // see R5
          if (all_idle) begin
            cmd_nxt = ba[`DDRC_EMRS_BIT] ? ddrc_pkg::CMD_EMRS : ddrc_pkg::CMD_MRS;
          end
        end
        3'h6: begin
          err_nxt = !burst_act_r; // see R6
          if (burst_act_r) begin
            cmd_nxt = ddrc_pkg::CMD_BST;
          end
        end
        3'h1: begin
          err_nxt = !all_idle; // see R2
          if (all_idle) begin
            cmd_nxt = ddrc_pkg::CMD_REF;
          end
        end
        default: begin
          cmd_nxt = ddrc_pkg::CMD_NOP;
        end
      endcase
    end
    if (st_nxt == ddrc_pkg::ST_IDLE || st_nxt == ddrc_pkg::ST_ACTV) begin
      st_nxt = (bank_nxt != 4'h0) ? ddrc_pkg::ST_ACTV : ddrc_pkg::ST_IDLE;
    end
  end

  // Command result and device state
  always_ff @(posedge link_ck or negedge lrst_n) begin
    if (!lrst_n) begin
      cke_prev_r     <= 1'b0;
      cmd_r          <= ddrc_pkg::CMD_NONE;
      cmd_err_r      <= 1'b0;
      cmd_bank_r     <= 2'h0;
      cmd_auto_pre_r <= 1'b0;
      dev_st_r       <= ddrc_pkg::ST_IDLE;
      bank_open_r    <= 4'h0;
    end else begin
      cke_prev_r     <= cke; // see R3
      cmd_r          <= cmd_nxt;
      cmd_err_r      <= err_nxt;
      cmd_bank_r     <= ba;
      cmd_auto_pre_r <= addr[`DDRC_AP_BIT] && (go || cmd_nxt == ddrc_pkg::CMD_PREA);
      dev_st_r       <= st_nxt;
      bank_open_r    <= bank_nxt;
    end
  end

  // Mode registers and set-to-command gap
  always_ff @(posedge link_ck or negedge lrst_n) begin
    if (!lrst_n) begin
      mode_r     <= `DDRC_MODE_RST;
      ext_mode_r <= `DDRC_MODE_RST;
      mode_set_r <= 1'b0;
      mrd_cnt_r  <= 2'h0;
    end else begin
      if (cmd_nxt == ddrc_pkg::CMD_MRS) begin
        mode_r     <= {ba, addr}; // see R10, R12, R14, R24
        mode_set_r <= 1'b1;
      end
      if (cmd_nxt == ddrc_pkg::CMD_EMRS) begin
        ext_mode_r <= {ba, addr}; // see R24
      end
      if (cmd_nxt == ddrc_pkg::CMD_MRS || cmd_nxt == ddrc_pkg::CMD_EMRS) begin
        mrd_cnt_r <= `DDRC_TMRD - 2'h1;
      end else if (mrd_cnt_r != 2'h0) begin
        mrd_cnt_r <= mrd_cnt_r - 2'h1;
      end
    end
  end

  // Two beats per clock, even and odd column
  assign gen_start = go ? addr[9:0] : start_r;
  assign pair_sel  = go ? 2'h0 : pair_r;
  ddrc_burst_col u_col_even (
    .start_col  (gen_start),
    .beat       ({pair_sel, 1'b0}),
    .len_mask   (len_mask),
    .interleave (mode_r[`DDRC_BT_BIT]),
    .col        (gen_even)
  );
  ddrc_burst_col u_col_odd (
    .start_col  (gen_start),
    .beat       ({pair_sel, 1'b1}),
    .len_mask   (len_mask),
    .interleave (mode_r[`DDRC_BT_BIT]),
    .col        (gen_odd)
  );

  // Burst sequencer
  always_ff @(posedge link_ck or negedge lrst_n) begin
    if (!lrst_n) begin
      burst_act_r  <= 1'b0;
      burst_wr_r   <= 1'b0;
      burst_ap_r   <= 1'b0;
      burst_bank_r <= 2'h0;
      start_r      <= 10'h000;
      pairs_left_r <= 2'h0;
      pair_r       <= 2'h0;
      col_even_r   <= 10'h000;
      col_odd_r    <= 10'h000;
      wr_lane_en_r <= 2'h0;
    end else begin
      if (go) begin
        burst_act_r  <= 1'b1;
        burst_wr_r   <= wr_go;
        burst_ap_r   <= addr[`DDRC_AP_BIT];
        burst_bank_r <= ba;
        start_r      <= addr[9:0];
        pairs_left_r <= pairs_m1; // see R17
        pair_r       <= 2'h1;
      end else if (burst_on) begin
        pairs_left_r <= pairs_left_r - 2'h1;
        pair_r       <= pair_r + 2'h1;
      end else if (burst_act_r) begin
        burst_act_r <= 1'b0; // see R6
        burst_ap_r  <= 1'b0;
      end
      if (go || burst_on) begin
        col_even_r <= gen_even; // see R18, R19, R20
        col_odd_r  <= gen_odd;
      end
      if (wr_go || (burst_on && burst_wr_r)) begin
        wr_lane_en_r <= ~{upper_byte_write_mask, lower_byte_write_mask}; // see R9
      end else begin
        wr_lane_en_r <= 2'h0;
      end
    end
  end

  // Read latency pipe
  always_ff @(posedge link_ck or negedge lrst_n) begin
    if (!lrst_n) begin
      rd_pipe_r  <= 2'h0;
      rd_start_r <= 1'b0;
      rd_half_r  <= 1'b0;
    end else begin
      rd_pipe_r  <= {1'b0, rd_pipe_r[1]} | (rd_go ? (cl3 ? 2'h2 : 2'h1) : 2'h0); // see R21
      rd_start_r <= rd_pipe_r[0];
      rd_half_r  <= rd_pipe_r[0] && cl_half;
    end
  end

  // Mode words to system clock by toggle handshake
  ddrc_sync #(.W(1)) u_ack (
    .clk   (link_ck),
    .rst_n (lrst_n),
    .d     (ack_r),
    .q_r   (ack_q)
  );
  always_ff @(posedge link_ck or negedge lrst_n) begin
    if (!lrst_n) begin
      upd_pend_r <= 1'b0;
      req_r      <= 1'b0;
      xfer_r     <= 32'h0000_0000;
    end else begin
      if (cmd_nxt == ddrc_pkg::CMD_MRS || cmd_nxt == ddrc_pkg::CMD_EMRS) begin
        upd_pend_r <= 1'b1;
      end else if (upd_pend_r && req_r == ack_q) begin
        upd_pend_r <= 1'b0;
      end
      if (upd_pend_r && req_r == ack_q) begin
        xfer_r <= {ext_mode_r, mode_r};
        req_r  <= ~req_r;
      end
    end
  end
  ddrc_sync #(.W(1)) u_req (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (req_r),
    .q_r   (req_q)
  );
  ddrc_sync #(.W(5)) u_state (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({bank_open_r, dev_st_r[2]}),
    .q_r   (st_q)
  );

  // System side copies
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r           <= 1'b0;
      sys_mode_r      <= `DDRC_MODE_RST;
      sys_ext_mode_r  <= `DDRC_MODE_RST;
      sys_bank_open_r <= 4'h0;
      sys_self_ref_r  <= 1'b0;
    end else begin
      if (req_q != ack_r) begin
        sys_mode_r     <= xfer_r[15:0];
        sys_ext_mode_r <= xfer_r[31:16];
        ack_r          <= req_q;
      end
      sys_bank_open_r <= st_q[4:1];
      sys_self_ref_r  <= st_q[0];
    end
  end

  // Checks on the link side
  default clocking cb @(posedge link_ck);
  endclocking
  default disable iff (!lrst_n);

  act_open_a: assert property (!pwr && cke_prev_r && cke && !cs_n && strb == 3'h3 // see R1
    && mrd_cnt_r == 2'h0 && !bank_open_r[ba]
    |=> cmd_r == ddrc_pkg::CMD_ACT && bank_open_r[cmd_bank_r])
    else $error("activate not decoded or bank not opened");
  rd_closed_a: assert property (!pwr && cke_prev_r && cke && !cs_n && strb == 3'h5 // see R4
    && !bank_open_r[ba] |=> cmd_err_r && cmd_r == ddrc_pkg::CMD_NONE)
    else $error("read to closed bank accepted");
  cke_qual_a: assert property (!pwr && !cke_prev_r // see R3
    |=> cmd_r == ddrc_pkg::CMD_NONE)
    else $error("command accepted with earlier enable low");
  mode_load_a: assert property (!pwr && cke_prev_r && cke && !cs_n && strb == 3'h0 // see R12
    && all_idle && mrd_cnt_r == 2'h0
    |=> (cmd_bank_r[0] ? ext_mode_r : mode_r) == {cmd_bank_r, $past(addr)})
    else $error("mode register not loaded from pins");
  bst_only_a: assert property (!pwr && cke_prev_r && cke && !cs_n && strb == 3'h6 // see R6
    && mrd_cnt_r == 2'h0 && !burst_act_r |=> cmd_err_r)
    else $error("burst stop accepted outside a burst");
  sref_cycle_a: assert property (dev_st_r == ddrc_pkg::ST_IDLE && cke_prev_r // see R2
    && !cke && !cs_n && strb == 3'h1 ##1 cke && idle_cmd
    |=> dev_st_r == ddrc_pkg::ST_IDLE && cmd_r == ddrc_pkg::CMD_SREF_OUT)
    else $error("self refresh entry or exit wrong");
  ppd_entry_a: assert property (dev_st_r == ddrc_pkg::ST_IDLE && cke_prev_r // see R7
    && !cke && idle_cmd |=> dev_st_r == ddrc_pkg::ST_PPD)
    else $error("precharge power-down not entered");
  apd_entry_a: assert property (dev_st_r == ddrc_pkg::ST_ACTV && cke_prev_r // see R8
    && !cke |=> dev_st_r == ddrc_pkg::ST_APD ##1 (dev_st_r != ddrc_pkg::ST_IDLE))
    else $error("active power-down not entered");
  lane_mask_a: assert property (!pwr && cke_prev_r && cke && !cs_n && strb == 3'h4 // see R9
    && mrd_cnt_r == 2'h0 && bank_open_r[ba] && !upper_byte_write_mask
    && lower_byte_write_mask |=> wr_lane_en_r == 2'h2)
    else $error("write lane mask wrong");
  seq_col_a: assert property (burst_act_r && !mode_r[`DDRC_BT_BIT] // see R19
    |-> (3'(col_odd_r[2:0] - col_even_r[2:0]) & len_mask) == 3'h1
    && col_odd_r[9:3] == col_even_r[9:3])
    else $error("sequential column order wrong");
  ilv_col_a: assert property (burst_act_r && mode_r[`DDRC_BT_BIT] // see R20
    |-> (col_odd_r ^ col_even_r) == 10'h001)
    else $error("interleaved column order wrong");
  rd_lat_a: assert property (cmd_r == ddrc_pkg::CMD_RD && cl3 // see R21
    |-> ##2 rd_start_r)
    else $error("read data start not at latency");
  cv_sref: cover property (dev_st_r == ddrc_pkg::ST_SREF ##[1:20] cmd_r == ddrc_pkg::CMD_SREF_OUT);
  cv_read: cover property (cmd_r == ddrc_pkg::CMD_RD ##[1:3] rd_start_r);
  cv_mrs: cover property (cmd_r == ddrc_pkg::CMD_MRS ##2 cmd_r == ddrc_pkg::CMD_ACT);
  cv_apd: cover property (dev_st_r == ddrc_pkg::ST_APD ##[1:20] dev_st_r == ddrc_pkg::ST_ACTV);
endmodule
`default_nettype wire

// ==== test/ddrc_ctrl_model.sv ====
// Memory controller model driving commands on the link clock
`timescale 1ns/1ps
`default_nettype none
module ddrc_ctrl_model (
  input  wire logic        link_ck,
  output logic             cke,
  output logic             cs_n,
  output logic             ras_n,
  output logic             cas_n,
  output logic             we_n,
  output logic [1:0]       ba,
  output logic [13:0]      addr,
  output logic [1:0]       dm
);
  // Deselected bus with clock enable low at time zero
  initial begin
    cke = 1'b0;
    {cs_n, ras_n, cas_n, we_n} = 4'hf;
    ba = 2'h0;
    addr = 14'h0000;
    dm = 2'h0;
  end

  // One command per link edge, strobes as {cs,ras,cas,we}
  task automatic cmd(input logic [3:0] s, input logic [1:0] b, input logic [13:0] a,
                     input logic k, input logic [1:0] m);
    @(posedge link_ck);
    cke <= k;
    {cs_n, ras_n, cas_n, we_n} <= s;
    ba <= s[3] ? ~ba : b; // Deselected lines do not hold
    addr <= s[3] ? ~addr : a;
    dm <= m;
  endtask
endmodule
`default_nettype wire

// ==== test/ddr_sdram_command_mode_decode_test.sv ====
// Self-checking bench for the command decoder
`timescale 1ns/1ps
`default_nettype none
module ddr_sdram_command_mode_decode_test;
  typedef struct packed {
    logic [3:0]          s;
    logic [1:0]          b;
    logic [13:0]         a;
    ddrc_pkg::ddrc_cmd_e c;
    logic [3:0]          o;
  } ddrc_row_s;
  logic                  clk = 1'b0;
  logic                  link_ck = 1'b0;
  logic                  arst_n = 1'b0;
  int                    n_mismatch = 0;
  int                    tests_run = 0;
  logic                  cke, cs_n, ras_n, cas_n, we_n, cmd_err_r, rd_start_r, rd_half_r;
  logic                  burst_act_r, burst_wr_r, cmd_auto_pre_r, mode_set_r, sys_self_ref_r;
  logic [1:0]            ba, dm, wr_lane_en_r;
  logic [3:0]            bank_open_r, sys_bank_open_r;
  logic [9:0]            col_even_r, col_odd_r;
  logic [13:0]           addr;
  logic [15:0]           mode_r, ext_mode_r, sys_mode_r, sys_ext_mode_r;
  ddrc_pkg::ddrc_cmd_e   cmd_r;
  ddrc_pkg::ddrc_state_e dev_st_r;
  // Interleaved column pairs of a burst of eight from column five
  logic [15:0]           ilv_exp [4] = '{16'h0504, 16'h0706, 16'h0100, 16'h0302};
  // Commands with zero undefined bits and legal codes only, gaps kept
  ddrc_row_s rows [15] = '{
    '{4'h0, 2'h0, 14'h32, ddrc_pkg::CMD_MRS, 4'h0}, '{4'h7, 2'h0, 14'h0, ddrc_pkg::CMD_NOP, 4'h0},
    '{4'h7, 2'h0, 14'h0, ddrc_pkg::CMD_NOP, 4'h0}, '{4'h3, 2'h1, 14'h0, ddrc_pkg::CMD_ACT, 4'h2},
    '{4'h5, 2'h1, 14'h5, ddrc_pkg::CMD_RD, 4'h2}, '{4'h7, 2'h0, 14'h0, ddrc_pkg::CMD_NOP, 4'h2},
    '{4'h2, 2'h1, 14'h0, ddrc_pkg::CMD_PRE, 4'h0}, '{4'h1, 2'h0, 14'h0, ddrc_pkg::CMD_REF, 4'h0},
    '{4'h0, 2'h1, 14'h0, ddrc_pkg::CMD_EMRS, 4'h0}, '{4'h7, 2'h0, 14'h0, ddrc_pkg::CMD_NOP, 4'h0},
    '{4'h7, 2'h0, 14'h0, ddrc_pkg::CMD_NOP, 4'h0}, '{4'h3, 2'h2, 14'h0, ddrc_pkg::CMD_ACT, 4'h4},
    '{4'h4, 2'h2, 14'h0, ddrc_pkg::CMD_WR, 4'h4}, '{4'h6, 2'h0, 14'h0, ddrc_pkg::CMD_BST, 4'h4},
    '{4'h2, 2'h0, 14'h0400, ddrc_pkg::CMD_PREA, 4'h0}};

  // Clocks of unrelated phase
  always #10 clk = ~clk;
  always #16 link_ck = ~link_ck;

  ddrc_ctrl_model u_ddrc_ctrl_model (.link_ck(link_ck), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dm(dm));

  ddrc_cmd_decode u_ddrc_cmd_decode (.clk(clk), .arst_n(arst_n), .link_ck(link_ck), .cke(cke),
    .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr),
    .lower_byte_write_mask(dm[0]), .upper_byte_write_mask(dm[1]), .cmd_r(cmd_r),
    .cmd_err_r(cmd_err_r), .cmd_bank_r(), .cmd_auto_pre_r(cmd_auto_pre_r), .dev_st_r(dev_st_r),
    .bank_open_r(bank_open_r), .burst_act_r(burst_act_r), .burst_wr_r(burst_wr_r),
    .col_even_r(col_even_r),
    .col_odd_r(col_odd_r), .wr_lane_en_r(wr_lane_en_r), .rd_start_r(rd_start_r),
    .rd_half_r(rd_half_r), .mode_r(mode_r), .ext_mode_r(ext_mode_r), .mode_set_r(mode_set_r),
    .sys_mode_r(sys_mode_r), .sys_ext_mode_r(sys_ext_mode_r), .sys_bank_open_r(sys_bank_open_r),
    .sys_self_ref_r(sys_self_ref_r));

  // Compare and count
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Issue one command; results checked after it are those of the previous command
  task automatic step(input logic [3:0] s, input logic [1:0] b, input logic [13:0] a,
                      input logic k, input logic [1:0] m);
    u_ddrc_ctrl_model.cmd(s, b, a, k, m);
    #2;
  endtask

  // Counts and verdict
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) step(4'h7, 2'h0, 14'h0, 1'b1, 2'h0);
    check("reset state", 16'(dev_st_r), 16'h0001);
    check("reset cmd", 16'(cmd_r), 16'h0000);
    for (int i = 0; i <= 15; i++) begin
      if (i < 15) step(rows[i].s, rows[i].b, rows[i].a, 1'b1, 2'h0);
      else step(4'h7, 2'h0, 14'h0, 1'b1, 2'h0);
      if (i > 0) check("cmd", 16'(cmd_r), 16'(rows[i-1].c));
      if (i > 0) check("banks", 16'(bank_open_r), 16'(rows[i-1].o));
    end
    check("ext mode", ext_mode_r, 16'h4000);
    $display("test table done");
    step(4'h3, 2'h1, 14'h0, 1'b1, 2'h0);
    step(4'h5, 2'h1, 14'h5, 1'b1, 2'h0);
    step(4'h7, 2'h0, 14'h0, 1'b1, 2'h0);
    check("seq cols", {col_even_r, col_odd_r[5:0]}, {10'h5, 6'h6});
    check("burst flags", 16'({burst_act_r, burst_wr_r}), 16'h2);
    step(4'h7, 2'h0, 14'h0, 1'b1, 2'h0);
    check("seq wrap", {col_even_r, col_odd_r[5:0]}, {10'h7, 6'h4});
    step(4'h7, 2'h0, 14'h0, 1'b1, 2'h0);
    check("cl3 start", 16'(rd_start_r), 16'h1);
    step(4'h5, 2'h3, 14'h0, 1'b1, 2'h0);
    step(4'h2, 2'h0, 14'h0400, 1'b1, 2'h0);
    check("closed bank", 16'({cmd_err_r, cmd_r}), 16'h10);
    step(4'h0, 2'h0, 14'h006b, 1'b1, 2'h0);
    step(4'h3, 2'h0, 14'h0, 1'b1, 2'h0);
    step(4'h3, 2'h0, 14'h0, 1'b1, 2'h0);
    check("mrs gap", 16'({cmd_err_r, cmd_r}), 16'h10);
    check("mode", mode_r, 16'h006b);
    step(4'h4, 2'h0, 14'h5, 1'b1, 2'h1);
    check("act", 16'(cmd_r), 16'(ddrc_pkg::CMD_ACT));
    $display("test read and mode done");
    for (int j = 0; j < 5; j++) begin
      step(j == 4 ? 4'h5 : 4'h7, 2'h0, 14'h0, 1'b1, j == 4 ? 2'h0 : 2'h2);
      check("lanes", 16'(wr_lane_en_r), j == 4 ? 16'h0 : (j == 0 ? 16'h2 : 16'h1));
      if (j < 4) check("ilv cols", {col_even_r[7:0], col_odd_r[7:0]}, ilv_exp[j]);
    end
    check("sys banks", 16'(sys_bank_open_r), 16'h1);
    step(4'h7, 2'h0, 14'h0, 1'b1, 2'h0);
    step(4'h7, 2'h0, 14'h0, 1'b1, 2'h0);
    check("cl25 start", 16'({rd_start_r, rd_half_r}), 16'h3);
    $display("test write interleave done");
    step(4'h7, 2'h0, 14'h0, 1'b0, 2'h0);
    step(4'h7, 2'h0, 14'h0, 1'b1, 2'h0);
    check("apd", 16'(dev_st_r), 16'h0010);
    step(4'h2, 2'h0, 14'h0400, 1'b1, 2'h0);
    check("apd exit", 16'(dev_st_r), 16'h0002);
    step(4'h7, 2'h0, 14'h0, 1'b0, 2'h0);
    check("auto pre", 16'({cmd_auto_pre_r, cmd_r}), 16'h14);
    step(4'h7, 2'h0, 14'h0, 1'b1, 2'h0);
    check("ppd", 16'(dev_st_r), 16'h0008);
    step(4'h1, 2'h0, 14'h0, 1'b0, 2'h0);
    check("ppd exit", 16'(dev_st_r), 16'h0001);
    step(4'h7, 2'h0, 14'h0, 1'b1, 2'h0);
    check("sref", 16'(dev_st_r), 16'h0004);
    step(4'h7, 2'h0, 14'h0, 1'b1, 2'h0);
    check("sref exit", 16'({dev_st_r, cmd_r}), 16'h001c);
    repeat (20) @(posedge clk);
    check("sys mode", sys_mode_r, 16'h006b);
    check("sys ext mode", sys_ext_mode_r, 16'h4000);
    check("sys status", 16'({mode_set_r, sys_bank_open_r, sys_self_ref_r}), 16'h20);
    $display("test power done");
    test_done();
  end

  // Watchdog for a hung run
  initial begin
    #20000;
    n_mismatch++;
    test_done();
  end
endmodule
`default_nettype wire
